// ### hdl/ccm_pkg.sv
package ccm_pkg;

    // register byte addresses
    localparam logic [7:0] CCM_ADDR_MODE = 8'h00;
    localparam logic [7:0] CCM_ADDR_STATUS = 8'h04;
    localparam logic [7:0] CCM_ADDR_INSTR = 8'h08;
    localparam logic [7:0] CCM_ADDR_TICKS = 8'h0C;

    // mode register field positions
    localparam int CCM_MODE_OSC_SEL = 0;
    localparam int CCM_MODE_PROC_LO = 1;
    localparam int CCM_MODE_DIV_LO = 3;
    localparam int CCM_MODE_STOP_A = 5;
    localparam int CCM_MODE_STOP_B = 6;
    localparam int CCM_MODE_LOCK = 7;

    // status register field positions
    localparam int CCM_STAT_PHI = 0;
    localparam int CCM_STAT_LOCK = 1;
    localparam int CCM_STAT_RC_DBL = 2;
    localparam int CCM_STAT_BUSY = 3;

    // division ratio encodings
    localparam logic [1:0] CCM_DIV_DOUBLE = 2'h0;
    localparam logic [1:0] CCM_DIV_HIGH = 2'h1;
    localparam logic [1:0] CCM_DIV_MIDDLE = 2'h2;

    // reset values
    localparam logic [1:0] CCM_DIV_RST = CCM_DIV_MIDDLE;
    localparam logic [1:0] CCM_PROC_RST = 2'h0;

    // oscillator falling edges per half system period, minus one
    localparam logic [2:0] CCM_HALF_HIGH = 3'h0;
    localparam logic [2:0] CCM_HALF_MIDDLE = 3'h3;

    // bus responses
    localparam logic [1:0] CCM_RESP_OKAY = 2'h0;
    localparam logic [1:0] CCM_RESP_SLVERR = 2'h2;

    // master to slave signals
    typedef struct packed {
        logic [7:0] awaddr;
        logic [2:0] awprot;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [7:0] araddr;
        logic [2:0] arprot;
        logic arvalid;
        logic rready;
    } ccm_axil_req_t;

    // slave to master signals
    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } ccm_axil_rsp_t;

endpackage : ccm_pkg

// ### hdl/ccm_clock_mode.sv
// The AXI4-Lite slave port and the address map were left to the implementer.
`timescale 1ns/1ps
module ccm_clock_mode
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire ccm_pkg::ccm_axil_req_t axi_req,
    output ccm_pkg::ccm_axil_rsp_t axi_rsp,
    input wire logic main_osc_input,
    output logic sys_clk,
    output logic sys_tick,
    output logic osc_sel,
    output logic [1:0] proc_mode,
    output logic osc_stop_ctrl_a,
    output logic osc_stop_ctrl_b,
    output logic instr_done
);
    import ccm_pkg::*;

    // bus state
    logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
    logic [7:0] awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic awready_q, awready_d, wready_q, wready_d;
    logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic wr_fire;
    // configuration state
    logic osc_sel_q, osc_sel_d, lock_q, lock_d;
    logic [1:0] proc_q, proc_d, div_q, div_d;
    logic stop_a_q, stop_a_d, stop_b_q, stop_b_d;
    // divider state
    logic osc_q, osc_d, phi_q, phi_d, tick_q, tick_d;
    logic [2:0] cnt_q, cnt_d;
    // instruction timer state
    logic [7:0] rem_q, rem_d;
    logic busy_q, busy_d, done_q, done_d;
    logic [31:0] ticks_q, ticks_d;

    // true when the address hits a register
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == CCM_ADDR_MODE) || (a == CCM_ADDR_STATUS) ||
                 (a == CCM_ADDR_INSTR) || (a == CCM_ADDR_TICKS);
    endfunction : mapped

    // read data for an address
    function automatic logic [31:0] rd_value(input logic [7:0] a);
        rd_value = 32'h0000_0000;
        if (a == CCM_ADDR_MODE)
        begin
            rd_value[CCM_MODE_OSC_SEL] = osc_sel_q;
            rd_value[CCM_MODE_PROC_LO +: 2] = proc_q;
            rd_value[CCM_MODE_DIV_LO +: 2] = div_q;
            rd_value[CCM_MODE_STOP_A] = stop_a_q;
            rd_value[CCM_MODE_STOP_B] = stop_b_q;
            rd_value[CCM_MODE_LOCK] = lock_q;
        end
        else if (a == CCM_ADDR_STATUS)
        begin
            rd_value[CCM_STAT_PHI] = phi_q;
            rd_value[CCM_STAT_LOCK] = lock_q;
            rd_value[CCM_STAT_RC_DBL] = osc_sel_q && (div_q == CCM_DIV_DOUBLE);
            rd_value[CCM_STAT_BUSY] = busy_q;
        end
        else if (a == CCM_ADDR_INSTR)
        begin
            rd_value[7:0] = rem_q;
        end
        else if (a == CCM_ADDR_TICKS)
        begin
            rd_value = ticks_q;
        end
    endfunction : rd_value

    // half period length for a division ratio
    function automatic logic [2:0] half_len(input logic [1:0] d);
        half_len = (d == CCM_DIV_HIGH) ? CCM_HALF_HIGH : CCM_HALF_MIDDLE;
    endfunction : half_len

    assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;

    // axi4-lite slave next state
    always_comb
    begin
        aw_hold_d = aw_hold_q;
        w_hold_d = w_hold_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        if (axi_req.awvalid && awready_q)
        begin
            aw_hold_d = 1'b1;
            awaddr_d = axi_req.awaddr;
        end
        if (axi_req.wvalid && wready_q)
        begin
            w_hold_d = 1'b1;
            wdata_d = axi_req.wdata;
            wstrb_d = axi_req.wstrb;
        end
        if (bvalid_q && axi_req.bready)
        begin
            bvalid_d = 1'b0;
        end
        if (wr_fire)
        begin
            aw_hold_d = 1'b0;
            w_hold_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = mapped(awaddr_q) ? CCM_RESP_OKAY : CCM_RESP_SLVERR;
        end
        if (rvalid_q && axi_req.rready)
        begin
            rvalid_d = 1'b0;
        end
        if (axi_req.arvalid && arready_q)
        begin
            rvalid_d = 1'b1;
            rdata_d = rd_value(axi_req.araddr);
            rresp_d = mapped(axi_req.araddr) ? CCM_RESP_OKAY : CCM_RESP_SLVERR;
        end
        awready_d = !aw_hold_d && !bvalid_d;
        wready_d = !w_hold_d && !bvalid_d;
        arready_d = !rvalid_d;
    end

    // mode register next state
    always_comb
    begin
        osc_sel_d = osc_sel_q;
        proc_d = proc_q;
        lock_d = lock_q;
        div_d = div_q;
        stop_a_d = stop_a_q;
        stop_b_d = stop_b_q;
        if (wr_fire && (awaddr_q == CCM_ADDR_MODE) && wstrb_q[0])
        begin
            if (!lock_q)
            begin
                osc_sel_d = wdata_q[CCM_MODE_OSC_SEL];
                proc_d = wdata_q[CCM_MODE_PROC_LO +: 2];
                lock_d = 1'b1;
            end
            // reserved ratio code keeps the old ratio
            if (wdata_q[CCM_MODE_DIV_LO +: 2] != 2'h3)
            begin
                div_d = wdata_q[CCM_MODE_DIV_LO +: 2];
            end
            stop_a_d = wdata_q[CCM_MODE_STOP_A];
            stop_b_d = wdata_q[CCM_MODE_STOP_B];
        end
    end

    // clock divider next state
    always_comb
    begin
        osc_d = main_osc_input;
        cnt_d = cnt_q;
        phi_d = phi_q;
        unique case (div_q)
            CCM_DIV_DOUBLE:
            begin
                phi_d = osc_q;
                cnt_d = 3'h0;
            end
            default:
            begin
                if (osc_q && !main_osc_input)
                begin
                    if (cnt_q >= half_len(div_q))
                    begin
                        cnt_d = 3'h0;
                        phi_d = !phi_q;
                    end
                    else
                    begin
                        cnt_d = cnt_q + 3'h1;
                    end
                end
            end
        endcase
        tick_d = phi_d && !phi_q;
    end

    // instruction cycle timer next state
    always_comb
    begin
        rem_d = rem_q;
        busy_d = busy_q;
        done_d = 1'b0;
        ticks_d = tick_q ? ticks_q + 32'h0000_0001 : ticks_q;
        if (busy_q && tick_q)
        begin
            rem_d = rem_q - 8'h01;
            if (rem_q == 8'h01)
            begin
                busy_d = 1'b0;
                done_d = 1'b1;
            end
        end
        if (wr_fire && (awaddr_q == CCM_ADDR_INSTR) && wstrb_q[0] && (wdata_q[7:0] != 8'h00))
        begin
            rem_d = wdata_q[7:0];
            busy_d = 1'b1;
        end
    end

    // registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= CCM_RESP_OKAY;
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rresp_q <= CCM_RESP_OKAY;
            rdata_q <= 32'h0000_0000;
            osc_sel_q <= 1'b0;
            proc_q <= CCM_PROC_RST;
            lock_q <= 1'b0;
            div_q <= CCM_DIV_RST;
            stop_a_q <= 1'b0;
            stop_b_q <= 1'b0;
            osc_q <= 1'b0;
            phi_q <= 1'b0;
            tick_q <= 1'b0;
            cnt_q <= 3'h0;
            rem_q <= 8'h00;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            ticks_q <= 32'h0000_0000;
        end
        else
        begin
            aw_hold_q <= aw_hold_d;
            w_hold_q <= w_hold_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
            osc_sel_q <= osc_sel_d;
            proc_q <= proc_d;
            lock_q <= lock_d;
            div_q <= div_d;
            stop_a_q <= stop_a_d;
            stop_b_q <= stop_b_d;
            osc_q <= osc_d;
            phi_q <= phi_d;
            tick_q <= tick_d;
            cnt_q <= cnt_d;
            rem_q <= rem_d;
            busy_q <= busy_d;
            done_q <= done_d;
            ticks_q <= ticks_d;
        end
    end

    // outputs straight from flops
    // one driver for the whole response struct
    assign axi_rsp = '{awready: awready_q, wready: wready_q, bresp: bresp_q, bvalid: bvalid_q,
                       arready: arready_q, rdata: rdata_q, rresp: rresp_q, rvalid: rvalid_q};
    assign sys_clk = phi_q;
    assign sys_tick = tick_q;
    // source, mode and stop controls driven to the pins
    assign osc_sel = osc_sel_q;
    assign proc_mode = proc_q;
    assign osc_stop_ctrl_a = stop_a_q;
    assign osc_stop_ctrl_b = stop_b_q;
    assign instr_done = done_q;

    // double speed tracks the sampled oscillator
    property p_double_follow;
        @(posedge aclk) disable iff (!aresetn)
        (div_q == CCM_DIV_DOUBLE) && $stable(div_q) |=> (phi_q == $past(osc_q));
    endproperty
    a_double_follow: assert property (p_double_follow) else $error("double speed clock mismatch");

    // high speed flips on every oscillator fall
    property p_high_flip;
        @(posedge aclk) disable iff (!aresetn)
        (div_q == CCM_DIV_HIGH) && (cnt_q == 3'h0) && osc_q && !main_osc_input |=> (phi_q != $past(phi_q));
    endproperty
    a_high_flip: assert property (p_high_flip) else $error("high speed clock did not toggle");

    // middle speed holds until the fourth fall
    property p_mid_hold;
        @(posedge aclk) disable iff (!aresetn)
        (div_q == CCM_DIV_MIDDLE) && (cnt_q < 3'h3) |=> $stable(phi_q) && (div_q != CCM_DIV_MIDDLE || cnt_q <= 3'h3);
    endproperty
    a_mid_hold: assert property (p_mid_hold) else $error("middle speed clock toggled early");

    // timer ends the cycle after the last system tick
    property p_instr_end;
        @(posedge aclk) disable iff (!aresetn)
        busy_q && tick_q && (rem_q == 8'h01) && !wr_fire |=> !busy_q && instr_done ##1 !instr_done;
    endproperty
    a_instr_end: assert property (p_instr_end) else $error("instruction timer end wrong");

    // first mode write locks the source and mode fields
    property p_first_lock;
        @(posedge aclk) disable iff (!aresetn)
        wr_fire && (awaddr_q == CCM_ADDR_MODE) && wstrb_q[0] && !lock_q
        |=> lock_q && (osc_sel_q == $past(wdata_q[CCM_MODE_OSC_SEL]));
    endproperty
    a_first_lock: assert property (p_first_lock) else $error("mode register not locked");

    // locked fields never change
    property p_lock_hold;
        @(posedge aclk) disable iff (!aresetn)
        lock_q |=> lock_q && $stable(osc_sel_q) && $stable(proc_q);
    endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("locked mode bits changed");

    // write response follows in the same or the next cycle once both parts are held
    property p_bresp;
        @(posedge aclk) disable iff (!aresetn)
        aw_hold_q && w_hold_q |-> ##[0:1] bvalid_q;
    endproperty
    a_bresp: assert property (p_bresp) else $error("write response missing");

    c_high_tick: cover property (@(posedge aclk) disable iff (!aresetn) (div_q == CCM_DIV_HIGH) && tick_q);
    c_mid_tick: cover property (@(posedge aclk) disable iff (!aresetn) (div_q == CCM_DIV_MIDDLE) && tick_q);
    c_lock: cover property (@(posedge aclk) disable iff (!aresetn) $rose(lock_q));
    c_done: cover property (@(posedge aclk) disable iff (!aresetn) instr_done);

endmodule : ccm_clock_mode

// ### verif/tb.sv
`timescale 1ns/1ps
module tb;
    import ccm_pkg::*;
    logic aclk;
    logic aresetn;
    ccm_axil_req_t axi_req;
    ccm_axil_rsp_t axi_rsp;
    logic main_osc_input;
    logic sys_clk;
    logic sys_tick;
    logic osc_sel;
    logic [1:0] proc_mode;
    logic osc_stop_ctrl_a;
    logic osc_stop_ctrl_b;
    logic instr_done;
    int n_errors;
    int check_count;
    int osc_cnt;
    int m_osc, m_proc, m_div, m_lock, m_stop;
    int ratio_q[$];
    logic [31:0] rd;
    logic [1:0] rs;
    int per, n, t0, k;

    ccm_clock_mode u_ccm_clock_mode (
        .aclk(aclk),
        .aresetn(aresetn),
        .axi_req(axi_req),
        .axi_rsp(axi_rsp),
        .main_osc_input(main_osc_input),
        .sys_clk(sys_clk),
        .sys_tick(sys_tick),
        .osc_sel(osc_sel),
        .proc_mode(proc_mode),
        .osc_stop_ctrl_a(osc_stop_ctrl_a),
        .osc_stop_ctrl_b(osc_stop_ctrl_b),
        .instr_done(instr_done)
    );

    // bench clock, 4 ns period
    initial aclk = 1'b0;
    always #2 aclk = ~aclk;

    // oscillator input, 8 aclk period, slow enough for the sampler
    always @(posedge aclk)
    begin
        if (osc_cnt == 3)
        begin
            osc_cnt <= 0;
            main_osc_input <= ~main_osc_input;
        end
        else
            osc_cnt <= osc_cnt + 1;
    end

    // compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR at %0t: seen 0x%0h expected 0x%0h", $time, seen, exp);
        end
    endtask : check

    // verdict and end of run
    task automatic wrap_up;
        if (n_errors == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : wrap_up

    // bus write: address and data offered together, held until taken
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
        int i;
        @(posedge aclk);
        axi_req.awaddr <= a;
        axi_req.awvalid <= 1'b1;
        axi_req.wdata <= d;
        axi_req.wstrb <= s;
        axi_req.wvalid <= 1'b1;
        axi_req.bready <= 1'b1;
        r = 2'h3;
        for (i = 0; i < 200; i++)
        begin
            @(posedge aclk);
            if (axi_req.awvalid && axi_rsp.awready)
                axi_req.awvalid <= 1'b0;
            if (axi_req.wvalid && axi_rsp.wready)
                axi_req.wvalid <= 1'b0;
            if (axi_rsp.bvalid)
            begin
                r = axi_rsp.bresp;
                axi_req.bready <= 1'b0;
                break;
            end
        end
    endtask : axi_write

    // bus read: rready held until the answer is sampled
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int i;
        @(posedge aclk);
        axi_req.araddr <= a;
        axi_req.arvalid <= 1'b1;
        axi_req.rready <= 1'b1;
        r = 2'h3;
        d = 32'hFFFFFFFF;
        for (i = 0; i < 200; i++)
        begin
            @(posedge aclk);
            if (axi_req.arvalid && axi_rsp.arready)
                axi_req.arvalid <= 1'b0;
            if (axi_rsp.rvalid)
            begin
                r = axi_rsp.rresp;
                d = axi_rsp.rdata;
                axi_req.rready <= 1'b0;
                break;
            end
        end
    endtask : axi_read

    // mode register as the model sees it
    function automatic logic [31:0] mode_val();
        return 32'(m_osc + m_proc * 2 + m_div * 8 + m_stop * 32 + m_lock * 128);
    endfunction : mode_val

    // write mode register, update model, compare read-back and pins
    task automatic mode_write(input logic [31:0] d, input logic [3:0] s);
        axi_write(CCM_ADDR_MODE, d, s, rs);
        check(32'(rs), 32'(CCM_RESP_OKAY));
        if (s[0])
        begin
            if (m_lock == 0)
            begin
                m_osc = d[0];
                m_proc = d[2:1];
                m_lock = 1;
            end
            if (d[4:3] != 2'h3)
                m_div = d[4:3];
            m_stop = d[6:5];
        end
        axi_read(CCM_ADDR_MODE, rd, rs);
        check(rd, mode_val());
        check(32'({osc_stop_ctrl_b, osc_stop_ctrl_a, proc_mode, osc_sel}), 32'(m_osc + m_proc * 2 + m_stop * 8));
    endtask : mode_write

    // cycles up to and including the next system tick
    task automatic tick_wait(output int cyc);
        cyc = 0;
        do
        begin
            @(posedge aclk);
            cyc++;
        end
        while (sys_tick !== 1'b1 && cyc < 1000);
    endtask : tick_wait

    // main sequence
    initial
    begin
        axi_req = '0;
        aresetn = 1'b0;
        main_osc_input = 1'b0;
        osc_cnt = 0;
        n_errors = 0;
        check_count = 0;
        m_osc = 0;
        m_proc = 0;
        m_div = CCM_DIV_RST;
        m_lock = 0;
        m_stop = 0;
        ratio_q = '{1, 2, 8};
        n = $urandom(11339);
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        axi_read(CCM_ADDR_MODE, rd, rs);
        check(rd, mode_val());
        // strobe-less write must not use up the single write
        mode_write(32'h07, 4'h0);
        mode_write(32'(($urandom % 4) * 2 + 8), 4'hF);
        // second write tries to change source and mode
        mode_write(32'(($urandom % 4) * 2 + 1 + 16), 4'hF);
        mode_write(32'h18, 4'hF);
        axi_read(8'h10, rd, rs);
        check(32'(rs), 32'(CCM_RESP_SLVERR));
        axi_write(8'h14, 32'h1, 4'hF, rs);
        check(32'(rs), 32'(CCM_RESP_SLVERR));
        // each ratio: system period against oscillator period
        foreach (ratio_q[k])
        begin
            mode_write(32'(k * 8), 4'hF);
            tick_wait(per);
            tick_wait(per);
            tick_wait(per);
            check(32'(per), 32'(8 * ratio_q[k]));
            check(32'(sys_clk), 32'h1);
            axi_read(CCM_ADDR_STATUS, rd, rs);
            check(32'(rd[3:1]), 32'h1);
        end
        // instruction timer in middle-speed mode
        n = 1 + $urandom % 4;
        tick_wait(per);
        axi_write(CCM_ADDR_INSTR, 32'(n), 4'hF, rs);
        k = 0;
        t0 = 0;
        per = 0;
        while (instr_done !== 1'b1 && per < 2000)
        begin
            @(posedge aclk);
            per++;
            if (sys_tick === 1'b1)
            begin
                k++;
                if (k == 1)
                    t0 = per;
            end
        end
        check(32'(k), 32'(n));
        check(32'(per - t0), 32'((n - 1) * 64 + 1));
        axi_read(CCM_ADDR_INSTR, rd, rs);
        check(rd, 32'h0);
        axi_read(CCM_ADDR_STATUS, rd, rs);
        check(rd & 32'hFFFFFFFE, 32'h2);
        wrap_up();
    end

    // watchdog against a hung handshake
    initial
    begin
        repeat (20000) @(posedge aclk);
        n_errors++;
        wrap_up();
    end
endmodule : tb
